// ===== design/vpw_link_host_register_set.v
// host register set of the vpw data link controller
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "vpw_link_regs.vh"

module vpw_link_host_register_set #(
  parameter FAULT_CYCLES = `FAULT_CYCLES
) (
  // clock and reset
  input  wire        core_clk_in,
  input  wire        srst_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  // external clock and bus pins
  input  wire        ext_clk_in,
  input  wire        bus_rx_in,
  // protocol engine: tx fifo path
  output reg  [7:0]  tx_data_out,
  output reg         tx_first_out,
  output reg         tx_last_out,
  output reg         tx_push_out,
  input  wire        tx_push_ready_in,
  input  wire [3:0]  tx_level_in,
  // protocol engine: commands
  output reg         standby_out,
  output reg         send_break_out,
  output reg         ifr_send_out,
  output reg         ifr_crc_out,
  output reg         end_retry_out,
  output reg         abort_tx_out,
  output reg         bus_drive_in_use_out,
  input  wire        bus_drive_in,
  // protocol engine: rx fifo path
  input  wire [7:0]  rx_head_byte_in,
  input  wire        rx_head_is_code_in,
  input  wire [3:0]  rx_count_in,
  input  wire        rx_more_frame_in,
  output reg         rx_pop_out,
  output reg         rx_flush_frame_out,
  // configuration applied to the engine
  output reg  [7:0]  config_out,
  output reg         config_now_out,
  output reg         link_tick_out,
  // interrupt sources and request
  input  wire        int_default_in,
  input  wire        int_extra_in,
  output reg         int_req_out,
  output reg         int_req_n_out
);

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  localparam TX_FULL_LEVEL   = 4'hF;
  localparam TX_ALMOST_LEVEL = 4'hA;

  reg [1:0] ext_clk_sync_ff;
  reg [1:0] bus_rx_sync_ff;
  reg       ext_clk_prev_ff;
  wire      ext_clk_s = ext_clk_sync_ff[1];
  wire      bus_active_s = bus_rx_sync_ff[1];

  // two stages before anything reads pin levels
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      ext_clk_sync_ff <= 2'h0;
      bus_rx_sync_ff  <= 2'h0;
      ext_clk_prev_ff <= 1'b0;
    end else begin
      ext_clk_sync_ff <= {ext_clk_sync_ff[0], ext_clk_in};
      bus_rx_sync_ff  <= {bus_rx_sync_ff[0], bus_rx_in};
      ext_clk_prev_ff <= ext_clk_s;
    end
  end

  wire ext_rise = ext_clk_s & ~ext_clk_prev_ff;

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  wire acc     = psel_in & penable_in;
  wire hit_cmd = (paddr_in == `OFS_COMMAND);
  wire hit_cfg = (paddr_in == `OFS_CONFIG);
  wire hit_sts = (paddr_in == `OFS_STATUS);
  wire hit_cc  = (paddr_in == `OFS_COMPLETION);
  wire hit_rxd = (paddr_in == `OFS_RX_DATA);
  wire mapped  = hit_cmd | hit_cfg | hit_sts | hit_cc | hit_rxd;
  // command writes need the tx fifo to accept a routed byte
  wire [2:0] br_code = pwdata_in[`ROUTE_MSB:`ROUTE_LSB];
  wire to_fifo = (br_code == `BR_DATA) | (br_code == `BR_LAST) |
                 (br_code == `BR_FIRST) | (br_code == `BR_FIRST_LAST);
  wire stall   = acc & pwrite_in & hit_cmd & to_fifo & ~tx_push_ready_in;

  assign pready_out  = ~stall;
  // command is write only; config, status, completion and rx bytes are read only
  assign pslverr_out = acc & (~mapped | (pwrite_in & ~hit_cmd) |
                              (~pwrite_in & hit_cmd));
  wire cmd_wr = acc & pwrite_in & hit_cmd & ~stall;

  // -------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------
  reg [7:0] cfg_ff;
  reg [7:0] nxt_cfg;
  reg [7:0] cfg_pending_ff;
  reg [7:0] nxt_cfg_pending;
  reg       cfg_pending_vld_ff;
  reg       nxt_cfg_pending_vld;
  wire [2:0] gc_code = pwdata_in[`GEN_CMD_MSB:`GEN_CMD_LSB];
  wire [1:0] rc_code = pwdata_in[`RXCMD_MSB:`RXCMD_LSB];
  wire frame_idle = bus_active_s == 1'b0;

  // all three fields of one write act in the same cycle
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      standby_out        <= 1'b0;
      send_break_out     <= 1'b0;
      ifr_send_out       <= 1'b0;
      ifr_crc_out        <= 1'b0;
      end_retry_out      <= 1'b0;
      abort_tx_out       <= 1'b0;
      tx_push_out        <= 1'b0;
      tx_data_out        <= 8'h00;
      tx_first_out       <= 1'b0;
      tx_last_out        <= 1'b0;
      rx_pop_out         <= 1'b0;
      rx_flush_frame_out <= 1'b0;
    end else begin
      standby_out    <= cmd_wr & (gc_code == `GC_STANDBY);
      send_break_out <= cmd_wr & (gc_code == `GC_BREAK);
      end_retry_out  <= cmd_wr & (gc_code == `GC_END_RETRY);
      abort_tx_out   <= cmd_wr & (gc_code == `GC_ABORT);
      ifr_send_out   <= cmd_wr & ((gc_code == `GC_IFR_CRC) |
                                  (gc_code == `GC_IFR_NOCRC));
      if (cmd_wr & ((gc_code == `GC_IFR_CRC) | (gc_code == `GC_IFR_NOCRC))) begin
        ifr_crc_out <= (gc_code == `GC_IFR_CRC);
      end
      tx_push_out <= cmd_wr & to_fifo;
      if (cmd_wr & to_fifo) begin
        tx_data_out  <= pwdata_in[15:8];
        tx_first_out <= (br_code == `BR_FIRST) | (br_code == `BR_FIRST_LAST);
        tx_last_out  <= (br_code == `BR_LAST) | (br_code == `BR_FIRST_LAST);
      end
      rx_pop_out         <= cmd_wr & (rc_code == `RC_FLUSH_BYTE);
      rx_flush_frame_out <= cmd_wr & (rc_code == `RC_FLUSH_FRAME);
    end
  end

  // -------------------------------------------------------------
  // configuration byte
  // -------------------------------------------------------------
  // normal loads wait for an idle bus so a frame keeps its timing
  always @* begin
    nxt_cfg             = cfg_ff;
    nxt_cfg_pending     = cfg_pending_ff;
    nxt_cfg_pending_vld = cfg_pending_vld_ff;
    if (cfg_pending_vld_ff & frame_idle) begin
      nxt_cfg             = cfg_pending_ff;
      nxt_cfg_pending_vld = 1'b0;
    end
    if (cmd_wr & (br_code == `BR_CONFIG)) begin
      nxt_cfg_pending     = pwdata_in[15:8];
      nxt_cfg_pending_vld = 1'b1;
    end
    if (cmd_wr & (br_code == `BR_CONFIG_NOW)) begin
      nxt_cfg             = pwdata_in[15:8];
      nxt_cfg_pending_vld = 1'b0;
    end
  end

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      cfg_ff             <= `CFG_RESET;
      cfg_pending_ff     <= `CFG_RESET;
      cfg_pending_vld_ff <= 1'b0;
      config_out         <= `CFG_RESET;
      config_now_out     <= 1'b0;
    end else begin
      cfg_ff             <= nxt_cfg;
      cfg_pending_ff     <= nxt_cfg_pending;
      cfg_pending_vld_ff <= nxt_cfg_pending_vld;
      config_out         <= nxt_cfg;
      config_now_out     <= cmd_wr & (br_code == `BR_CONFIG_NOW);
    end
  end

  wire       normal_mode = ~cfg_ff[`CFG_TEST_MODE] & (cfg_ff[6:5] == 2'h0);
  wire [1:0] div_sel     = cfg_ff[`CFG_DIV_MSB:`CFG_DIV_LSB];
  wire       fast        = cfg_ff[`CFG_HIGH_SPEED];

  // -------------------------------------------------------------
  // clock divider and link tick
  // -------------------------------------------------------------
  reg [1:0] div_cnt_ff;
  reg [1:0] fast_cnt_ff;
  reg       int_tick;

  // divisor is code plus one; fast mode lets every tick through
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      div_cnt_ff    <= 2'h0;
      fast_cnt_ff   <= 2'h0;
      link_tick_out <= 1'b0;
      int_tick      <= 1'b0;
    end else begin
      int_tick <= 1'b0;
      if (ext_rise) begin
        if (div_cnt_ff >= div_sel) begin
          div_cnt_ff <= 2'h0;
          int_tick   <= 1'b1;
        end else begin
          div_cnt_ff <= div_cnt_ff + 2'h1;
        end
      end
      link_tick_out <= 1'b0;
      if (int_tick) begin
        fast_cnt_ff   <= fast_cnt_ff + 2'h1;
        link_tick_out <= fast | (fast_cnt_ff == 2'h3);
      end
    end
  end

  // -------------------------------------------------------------
  // network fault watchdog
  // -------------------------------------------------------------
  reg [15:0] fault_cnt_ff;
  reg        fault_ff;
  reg        bus_drive_q_ff;
  wire [31:0] fault_lim = FAULT_CYCLES;

  // fault sticks until the next drive sees the bus go active
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      fault_cnt_ff         <= 16'h0000;
      fault_ff             <= 1'b0;
      bus_drive_q_ff       <= 1'b0;
      bus_drive_in_use_out <= 1'b0;
    end else begin
      bus_drive_q_ff       <= bus_drive_in;
      bus_drive_in_use_out <= bus_drive_in & ~fault_ff;
      if (!bus_drive_in | bus_active_s) begin
        fault_cnt_ff <= 16'h0000;
        if (bus_drive_in & bus_active_s) begin
          fault_ff <= 1'b0;
        end
      end else if (fault_cnt_ff >= fault_lim[15:0] - 16'h0001) begin
        fault_ff <= 1'b1;
      end else begin
        fault_cnt_ff <= fault_cnt_ff + 16'h0001;
      end
    end
  end

  // -------------------------------------------------------------
  // interrupt request
  // -------------------------------------------------------------
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      int_req_out   <= 1'b0;
      int_req_n_out <= 1'b1;
    end else begin
      int_req_out   <= ~cfg_ff[`CFG_IMASK] & normal_mode &
                       (int_default_in | (cfg_ff[`CFG_IMODE] & int_extra_in));
      int_req_n_out <= ~(~cfg_ff[`CFG_IMASK] & normal_mode &
                       (int_default_in | (cfg_ff[`CFG_IMODE] & int_extra_in)));
    end
  end

  // -------------------------------------------------------------
  // status and completion code
  // -------------------------------------------------------------
  reg [2:0] rx_state;
  reg [1:0] tx_state;

  // receive fifo state from head type and depth
  always @* begin
    rx_state = 3'h0;
    if (rx_count_in == 4'h0) begin
      rx_state = 3'h0;
    end else if (rx_head_is_code_in) begin
      if (rx_count_in == 4'h1) begin
        rx_state = 3'h7;
      end else if (rx_more_frame_in) begin
        rx_state = 3'h6;
      end else begin
        rx_state = 3'h5;
      end
    end else if (rx_count_in == 4'hD) begin
      rx_state = 3'h3;
    end else if (rx_count_in == 4'h1) begin
      rx_state = 3'h4;
    end else if (rx_more_frame_in) begin
      rx_state = 3'h2;
    end else begin
      rx_state = 3'h1;
    end
  end

  always @* begin
    tx_state = 2'h1;
    if (tx_level_in == 4'h0) begin
      tx_state = 2'h0;
    end else if (tx_level_in >= TX_FULL_LEVEL) begin
      tx_state = 2'h3;
    end else if (tx_level_in >= TX_ALMOST_LEVEL) begin
      tx_state = 2'h2;
    end
  end

  // bits 7:5 rx state, 4 bus idle, 3 fault, 2 fast, 1:0 tx fifo state
  wire [7:0] status_byte = {rx_state, ~bus_active_s, fault_ff, fast, tx_state};
  wire [7:0] completion  = rx_head_is_code_in ? rx_head_byte_in : 8'h00;

  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (hit_sts) begin
      rd_byte = status_byte;
    end else if (hit_cc) begin
      rd_byte = completion;
    end else if (hit_rxd) begin
      rd_byte = rx_head_byte_in;
    end
  end

  assign prdata_out = (acc & ~pwrite_in) ? {24'h000000, rd_byte} : 32'h00000000;

endmodule

// ===== design/vpw_link_regs.vh
// register map, field positions, reset values and timing counts
`ifndef VPW_LINK_REGS_VH
`define VPW_LINK_REGS_VH
// apb byte addresses
`define OFS_COMMAND        12'h000
`define OFS_CONFIG         12'h004
`define OFS_STATUS         12'h008
`define OFS_COMPLETION     12'h00C
`define OFS_RX_DATA        12'h010
// command byte fields
`define GEN_CMD_MSB        7
`define GEN_CMD_LSB        5
`define ROUTE_MSB          4
`define ROUTE_LSB          2
`define RXCMD_MSB          1
`define RXCMD_LSB          0
// general commands
`define GC_NOP             3'h0
`define GC_STANDBY         3'h1
`define GC_BREAK           3'h2
`define GC_IFR_CRC         3'h3
`define GC_END_RETRY       3'h4
`define GC_IFR_NOCRC       3'h5
`define GC_ABORT           3'h7
// byte routing codes
`define BR_NONE            3'h0
`define BR_DATA            3'h1
`define BR_LAST            3'h3
`define BR_CONFIG          3'h4
`define BR_FIRST           3'h5
`define BR_CONFIG_NOW      3'h6
`define BR_FIRST_LAST      3'h7
// receive fifo commands
`define RC_NOP             2'h0
`define RC_FLUSH_BYTE      2'h2
`define RC_FLUSH_FRAME     2'h3
// configuration byte
`define CFG_RESET          8'h06
`define CFG_TEST_MODE      7
`define CFG_IMASK          4
`define CFG_IMODE          3
`define CFG_DIV_MSB        2
`define CFG_DIV_LSB        1
`define CFG_HIGH_SPEED     0
// timing
`define CLK_FREQ_MHZ       50
`define FAULT_TIME_US      60
`define FAULT_CYCLES       (`FAULT_TIME_US * `CLK_FREQ_MHZ)
`endif

// ===== tb/tb_vpw_link_host_register_set.sv
// self-checking bench for the vpw host register set
`timescale 1ns/1ps
`include "vpw_link_regs.vh"
module tb_vpw_link_host_register_set;
  localparam int FAULT_LIM = 20;
  logic        core_clk_in, srst_in, psel_in, penable_in, pwrite_in, ext_clk_in, bus_rx_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        pready_out, pslverr_out, tx_first_out, tx_last_out, tx_push_out, tx_push_ready_in;
  logic [7:0]  tx_data_out, rx_head_byte_in, config_out, cfg_e;
  logic [3:0]  tx_level_in, rx_count_in;
  logic        standby_out, send_break_out, ifr_send_out, ifr_crc_out, end_retry_out;
  logic        abort_tx_out, bus_drive_in_use_out, bus_drive_in, rx_head_is_code_in;
  logic        rx_more_frame_in, rx_pop_out, rx_flush_frame_out, config_now_out, link_tick_out;
  logic        int_default_in, int_extra_in, int_req_out, int_req_n_out;
  logic        drain, rx_fill, dead, err, crc_e;
  logic [11:0] snap;
  logic [12:0] bad [4] = '{13'h0000, 13'h1008, 13'h1004, 13'h0020};
  logic [10:0] irq_t [5] = '{11'h606, 11'h216, 11'h106, 11'h50E, 11'h286};
  int          n_fail, cmp_count, ticks, t0, te, ec;

  vpw_link_host_register_set #(.FAULT_CYCLES(FAULT_LIM)) dut (.*);
  vpw_engine_model eng (
    .clk_in(core_clk_in), .srst_in(srst_in), .drain_in(drain), .rx_fill_in(rx_fill),
    .bus_dead_in(dead), .drive_in(bus_drive_in), .tx_push_in(tx_push_out),
    .tx_push_ready_out(tx_push_ready_in), .tx_level_out(tx_level_in), .rx_pop_in(rx_pop_out),
    .rx_flush_in(rx_flush_frame_out), .rx_count_out(rx_count_in),
    .rx_head_out(rx_head_byte_in), .rx_is_code_out(rx_head_is_code_in), .bus_rx_out(bus_rx_in));

  // core clock, and a slow external clock the synchroniser can follow
  initial begin
    core_clk_in = 0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    ec <= (ec + 1) % 3;
    if (ec == 2) ext_clk_in <= ~ext_clk_in;
    if (link_tick_out) ticks <= ticks + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; pulse outputs are caught in the cycle after it is taken
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel_in <= 1; penable_in <= 0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1;
    n = 0;
    do begin @(posedge core_clk_in); n++; end while (pready_out !== 1'b1 && n < 500);
    if (n >= 500) begin
      n_fail++;
      finish_test();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0; penable_in <= 0;
    #1 snap = {tx_push_out, tx_first_out, tx_last_out, standby_out, send_break_out,
      ifr_send_out, end_retry_out, abort_tx_out, rx_pop_out, rx_flush_frame_out,
      config_now_out, ifr_crc_out};
    @(posedge core_clk_in);
  endtask

  // command write against the decoded-field model
  task automatic cmd(input logic [7:0] c, input logic [7:0] b);
    logic [2:0]  g;
    logic [2:0]  r;
    logic [11:0] e;
    g = c[7:5];
    r = c[4:2];
    if (g == `GC_IFR_CRC || g == `GC_IFR_NOCRC) crc_e = (g == `GC_IFR_CRC);
    e = {r[0], r[2] & r[0], r[1] & r[0], g == `GC_STANDBY, g == `GC_BREAK,
      g == `GC_IFR_CRC || g == `GC_IFR_NOCRC, g == `GC_END_RETRY, g == `GC_ABORT,
      c[1:0] == `RC_FLUSH_BYTE, c[1:0] == `RC_FLUSH_FRAME, r == `BR_CONFIG_NOW, crc_e};
    apb(1'b1, `OFS_COMMAND, {16'h0000, b, c});
    chk(snap & (r[0] ? 12'hFFF : 12'h9FF), e, "pulses");
    if (r[0]) chk(tx_data_out, b, "tx byte");
    if (r == `BR_CONFIG_NOW) cfg_e = b;
    if (r != `BR_CONFIG) chk(config_out, cfg_e, "config");
    else cfg_e = b;
  endtask

  // rx state for n queued bytes, code at odd counts
  function automatic logic [2:0] rxs(input int n, input int m);
    if (n == 0) return 3'h0;
    if (n % 2) return m ? 3'h6 : (n == 1 ? 3'h7 : 3'h5);
    return m ? 3'h2 : 3'h1;
  endfunction

  task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #500_000;
    n_fail++;
    finish_test();
  end

  initial begin
    {srst_in, drain} = 2'h3;
    {psel_in, penable_in, pwrite_in, ext_clk_in, bus_drive_in, rx_more_frame_in} = 6'h00;
    {int_default_in, int_extra_in, rx_fill, dead, crc_e} = 5'h00;
    {paddr_in, pwdata_in, n_fail, cmp_count, ticks, ec} = 0;
    cfg_e = `CFG_RESET;
    void'($urandom(60));
    repeat (16) @(posedge core_clk_in);
    srst_in <= 0;
    @(posedge core_clk_in);
    chk(config_out, `CFG_RESET, "config reset");
    // wrong-direction and unmapped places are refused
    foreach (bad[i]) begin
      apb(bad[i][12], bad[i][11:0], 32'hFF);
      chk(err, 1, "refused");
    end
    // rx walk: two frames popped byte by byte, then a frame flush
    rx_fill <= 1;
    @(posedge core_clk_in);
    rx_fill <= 0;
    for (int n = 4; n >= 0; n--) begin
      rx_more_frame_in <= (n >= 3);
      apb(0, `OFS_STATUS, 0);
      chk(rd, {rxs(n, n >= 3), 5'h10}, "status");
      apb(0, `OFS_COMPLETION, 0);
      chk(rd, (n % 2) ? 32'hC0 + n : 32'h0, "completion");
      apb(0, `OFS_RX_DATA, 0);
      chk(rd, (n > 0) ? 32'hC0 + n : 32'hC0, "rx head");
      if (n > 0) cmd(8'h02, 8'h00);
    end
    rx_fill <= 1;
    @(posedge core_clk_in);
    rx_fill <= 0;
    cmd(8'h03, 8'h00);
    apb(0, `OFS_STATUS, 0);
    chk(rd[7:5], 3'h7, "flush keeps code");
    // every code of each field, then random commands
    for (int i = 0; i < 48; i++)
      cmd(i < 8 ? {i[2:0], i[2:0], i[1:0]} : 8'($urandom), 8'($urandom));
    // fill the tx fifo until it refuses, then drain
    drain <= 0;
    for (int k = 1; k <= 15; k++) begin
      cmd(8'h04, 8'(k));
      apb(0, `OFS_STATUS, 0);
      chk(rd[1:0], k >= 15 ? 2'h3 : (k >= 10 ? 2'h2 : 2'h1), "tx state");
    end
    fork
      cmd(8'h04, 8'hA5);
      begin
        repeat (6) @(posedge core_clk_in);
        chk(pready_out, 0, "full stalls");
        drain <= 1;
      end
    join
    repeat (20) @(posedge core_clk_in);
    apb(0, `OFS_STATUS, 0);
    chk(rd[1:0], 2'h0, "tx empty");
    // drive with no echo: fault only after the timeout, echo clears it
    bus_drive_in <= 1;
    dead <= 1;
    repeat (10) @(posedge core_clk_in);
    chk(bus_drive_in_use_out, 1, "drive early");
    apb(0, `OFS_STATUS, 0);
    chk(rd[4:3], 2'h2, "no fault yet");
    repeat (FAULT_LIM) @(posedge core_clk_in);
    apb(0, `OFS_STATUS, 0);
    chk(rd[4:3], 2'h3, "fault");
    chk(bus_drive_in_use_out, 0, "drive cut");
    dead <= 0;
    repeat (5) @(posedge core_clk_in);
    apb(0, `OFS_STATUS, 0);
    chk(rd[4:3], 2'h0, "bus active");
    bus_drive_in <= 0;
    // interrupt sources against mask, mode and test setting
    foreach (irq_t[i]) begin
      {int_default_in, int_extra_in} <= irq_t[i][9:8];
      cmd(8'h18, irq_t[i][7:0]);
      repeat (3) @(posedge core_clk_in);
      chk(int_req_out, irq_t[i][10], "irq");
      chk(int_req_n_out, !irq_t[i][10], "irq low");
    end
    // tick rate for each divisor, normal and fast
    for (int i = 0; i < 8; i++) begin
      cmd(8'h18, 8'(i));
      t0 = ticks;
      repeat (240) @(posedge core_clk_in);
      te = 40 / (i[2:1] + 1) / (i[0] ? 1 : 4);
      chk((ticks - t0) inside {[te - 1:te + 1]}, 1, "tick rate");
      apb(0, `OFS_STATUS, 0);
      chk(rd[2], i[0], "fast flag");
    end
    finish_test();
  end
endmodule

// ===== tb/vpw_engine_model.sv
// far-side protocol engine model: tx fifo, rx fifo and bus echo
`timescale 1ns/1ps
module vpw_engine_model (
  // clock, reset and bench knobs
  input  wire       clk_in,
  input  wire       srst_in,
  input  wire       drain_in,
  input  wire       rx_fill_in,
  input  wire       bus_dead_in,
  input  wire       drive_in,
  // tx fifo
  input  wire       tx_push_in,
  output wire       tx_push_ready_out,
  output reg  [3:0] tx_level_out,
  // rx fifo
  input  wire       rx_pop_in,
  input  wire       rx_flush_in,
  output reg  [3:0] rx_count_out,
  output wire [7:0] rx_head_out,
  output wire       rx_is_code_out,
  // bus level, 1 = active
  output wire       bus_rx_out
);
  // a full fifo refuses, which stalls the host write
  assign tx_push_ready_out = (tx_level_out != 4'hF);
  always @(posedge clk_in) begin
    if (srst_in)
      tx_level_out <= 4'h0;
    else if (drain_in && tx_level_out != 4'h0)
      tx_level_out <= tx_level_out - 4'h1;
    else if (tx_push_in)
      tx_level_out <= tx_level_out + 4'h1;
  end
  // two frames of data then code; odd counts hold a code at the head
  assign rx_is_code_out = rx_count_out[0];
  assign rx_head_out    = {4'hC, rx_count_out};
  always @(posedge clk_in) begin
    if (srst_in)
      rx_count_out <= 4'h0;
    else if (rx_fill_in)
      rx_count_out <= 4'h4;
    else if (rx_flush_in && rx_count_out != 4'h0)
      rx_count_out <= 4'h1;
    else if (rx_pop_in && rx_count_out != 4'h0)
      rx_count_out <= rx_count_out - 4'h1;
  end
  // line echoes the drive unless held dead
  assign bus_rx_out = drive_in & ~bus_dead_in;
endmodule

// ===== tb/vpw_link_monitor.sv
// port checker for the vpw host register set
`timescale 1ns/1ps
`include "vpw_link_regs.vh"
module vpw_link_monitor (
  // clock, reset and apb
  input wire        core_clk_in,
  input wire        srst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire        pready_out,
  // engine side
  input wire        tx_push_out,
  input wire        tx_first_out,
  input wire        tx_last_out,
  input wire [7:0]  tx_data_out,
  input wire        standby_out,
  input wire        send_break_out,
  input wire        ifr_send_out,
  input wire        ifr_crc_out,
  input wire        abort_tx_out,
  input wire        rx_pop_out,
  input wire [7:0]  config_out,
  input wire        int_req_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // ---------------------------------------
  // command write decode
  // ---------------------------------------
  wire       cmd_wr = psel_in & penable_in & pready_out & pwrite_in & (paddr_in == `OFS_COMMAND);
  wire [2:0] gen_cmd = pwdata_in[7:5];
  wire [2:0] route   = pwdata_in[4:2];
  sequence s_gen(logic [2:0] c);
    cmd_wr && gen_cmd == c;
  endsequence
  // a pulse lasts exactly one cycle
  sequence s_one(logic s);
    s ##1 !s;
  endsequence
  // ---------------------------------------
  // assertions
  // ---------------------------------------
  a_standby_pulse: assert property (s_gen(`GC_STANDBY) |=> s_one(standby_out))
    else $error("standby pulse wrong");
  a_break_pulse: assert property (s_gen(`GC_BREAK) |=> s_one(send_break_out))
    else $error("break pulse wrong");
  a_abort_pulse: assert property (s_gen(`GC_ABORT) |=> s_one(abort_tx_out))
    else $error("abort pulse wrong");
  a_reply_crc: assert property (s_gen(`GC_IFR_CRC) |=> ifr_send_out && ifr_crc_out)
    else $error("reply with crc wrong");
  a_reply_plain: assert property (s_gen(`GC_IFR_NOCRC) |=> ifr_send_out && !ifr_crc_out)
    else $error("reply without crc wrong");
  a_tx_route: assert property (cmd_wr && route[0] |=> tx_push_out &&
      tx_data_out == $past(pwdata_in[15:8]) && {tx_first_out, tx_last_out} == $past(route[2:1]))
    else $error("tx byte routing wrong");
  a_cfg_now: assert property (
      cmd_wr && route == `BR_CONFIG_NOW |=> config_out == $past(pwdata_in[15:8]))
    else $error("immediate config wrong");
  a_rx_pop: assert property (cmd_wr && pwdata_in[1:0] == `RC_FLUSH_BYTE |=> rx_pop_out)
    else $error("rx pop missing");
  a_irq_masked: assert property (
      config_out[`CFG_IMASK] && $past(config_out[`CFG_IMASK]) |-> !int_req_out)
    else $error("masked interrupt raised");
endmodule
bind vpw_link_host_register_set vpw_link_monitor mon (.*);
